// ### inc/sec_map.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 4-bit register address, 8-bit data
// Notes:   shared by the package users and the top module
`ifndef SEC_MAP_SVH
`define SEC_MAP_SVH

// ---------------------------------------------------------------------------
// register addresses
// ---------------------------------------------------------------------------
`define SEC_ADDR_CMD        4'h0
`define SEC_ADDR_DMA        4'h1
`define SEC_ADDR_RXCTL      4'h3
`define SEC_ADDR_MODE       4'h4
`define SEC_ADDR_TXCTL      4'h5
`define SEC_ADDR_SYNC_ENH   4'h7
`define SEC_ADDR_ENC        4'hA
`define SEC_ADDR_MISC       4'hE
`define SEC_ADDR_ACC        4'hF
`define SEC_RADDR_STAT0     4'h0
`define SEC_RADDR_RXCTL     4'h9
`define SEC_RADDR_MODE      4'h4
`define SEC_RADDR_TXCTL     4'h5
`define SEC_RADDR_ENH       4'hE
`define SEC_RADDR_ENC       4'hB

// ---------------------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------------------
`define SEC_ENH_RESET       8'h20
`define SEC_ACC_ENH_SEL     0
`define SEC_CMD_RST_TBE     0
`define SEC_CMD_RST_EOM     1
`define SEC_DMA_REQ_EN      0
`define SEC_DMA_REQ_RX      1
`define SEC_MISC_DTR_REQ    2
`define SEC_TXCTL_RTS       1
`define SEC_ENC_MARK_IDLE   3
`define SEC_STAT_TBE        2
`define SEC_STAT_RXAV       0
`define SEC_RX_HALF_LEVEL   4'h4

// ---------------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------------
`define SEC_DEACT_CLKS      4

`endif

// ### inc/sec_pkg.sv
// Purpose: types shared by the enhancement control block
// Assumes: field layout of the enhancement control register
// Notes:   bit 7 is reserved and kept only so the readback is whole
package sec_pkg;

  // -------------------------------------------------------------------------
  // enhancement control register layout
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic reserved;
    logic ext_read;
    logic tx_level;
    logic dtr_timing;
    logic rx_level;
    logic auto_rts;
    logic auto_eom;
    logic auto_flag;
  } sec_enh_t;

  // request-to-send hold sequence
  typedef enum logic [1:0] {SEC_RTS_FOLLOW, SEC_RTS_HOLD, SEC_RTS_CLKWAIT} sec_rts_st_t;

endpackage

// ### verilog/sec_sync.sv
// Purpose: two flip-flop synchroniser for pins from outside the core clock
// Assumes: i_d is asynchronous to i_clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module sec_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_reg;

  // two stages, constant reset
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_reg <= '0;
      o_q      <= '0;
    end
    else
    begin
      meta_reg <= i_d;
      o_q      <= meta_reg;
    end
  end

endmodule // sec_sync

// ### verilog/sec_req_deact.sv
// Purpose: active-low request pin with selectable deactivation delay
// Assumes: i_req is a level from core-clock logic
// Notes:   delayed mode holds the pin active for a fixed count after drop
`timescale 1ns/10ps
`include "sec_map.svh"
module sec_req_deact #(
  parameter int DEACT = `SEC_DEACT_CLKS
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_req,
  input  wire logic i_fast,
  output logic      o_req_n
);

  logic [3:0] cnt_reg;

  // count down the hold after the request drops
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cnt_reg <= 4'h0;
    else if (i_req)
      cnt_reg <= 4'(DEACT - 1);
    else if (cnt_reg != 4'h0)
      cnt_reg <= cnt_reg - 4'h1;
  end

  // fast mode drops with the request, like the wait/request pin
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_req_n <= 1'b1;
    else
      o_req_n <= !(i_req || (!i_fast && !o_req_n && cnt_reg != 4'h0));
  end

endmodule // sec_req_deact

// ### verilog/sec_chan.sv
// Purpose: per-channel enhancement control of a serial controller
// Assumes: fifo levels and transmitter events come from core-clock logic;
//          the transmit clock pin is sampled, not used as a clock
// Notes:   one instance per channel; nothing is shared between channels
//
// Notes on behaviour
// - with access bit 0 set, writes to address 7 go to enhancement control
// - access control bit 0 reads back as written
// - reset sets enhancement bit 5, clears the rest; channel reset does the same
// - extended read returns write registers at read addresses 9,4,5,14,11
// - tx empty interrupt on whole fifo empty or top byte empty per bit 5
// - transmit request follows the same bit 5 choice
// - terminal-ready request drops like wait request, or after 4 clocks
// - rx interrupt at four bytes when bit 3 set, else per character
// - sdlc auto rts holds rts until closing flag leaves, then tx clock edge
// - outside sdlc or with bit 2 clear, rts follows its control bit
// - auto eom clears the eom latch and presets the crc itself
// - auto flag sends an opening flag without clearing mark idle
// - sdlc receive stores the final two crc bits
// - other sync modes drop the final two crc bits
// - sdlc nrzi mark idle forces txd high when idle is reached
// - forced high is off while mark idle bit is 0
// - frame end gives two latched tx empty interrupts, two resets
// - tx pending latches when eom latch clears before frame end
// - status bit 2 shows top tx byte empty regardless of level
// - rx request with at least one byte, independent of bit 3
`timescale 1ns/10ps
`include "sec_map.svh"
module sec_chan
  import sec_pkg::*;
#(
  parameter int DEACT = `SEC_DEACT_CLKS
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_nrst,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  input  wire logic       i_chan_reset,
  input  wire logic       i_tx_top_empty,
  input  wire logic       i_tx_fifo_empty,
  input  wire logic       i_tx_data_wr,
  input  wire logic       i_crc_loaded,
  input  wire logic       i_frame_active,
  input  wire logic       i_flag_done,
  input  wire logic       i_eom_latch,
  input  wire logic       i_tx_mark_idle,
  input  wire logic       i_tx_serial,
  input  wire logic [3:0] i_rx_level,
  input  wire logic       i_tx_clk,
  output logic            o_txd,
  output logic            o_rts_n,
  output logic            o_w_req_n,
  output logic            o_dtr_req_n,
  output logic            o_tx_irq,
  output logic            o_rx_irq,
  output logic            o_eom_clr,
  output logic            o_crc_preset,
  output logic            o_auto_flag,
  output logic            o_rx_crc_full
);

  // -------------------------------------------------------------------------
  // reset release and pin sampling
  // -------------------------------------------------------------------------
  logic        rst_n;
  logic        txclk_s;
  logic        txclk_prev_reg;
  logic        txclk_rise;
  logic [1:0]  rst_sync_reg;

  // async assert, release through two flops
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  sec_sync #(.W(1)) u_txclk_sync (
    .i_clk   (i_core_clk),
    .i_rst_n (rst_n),
    .i_d     (i_tx_clk),
    .o_q     (txclk_s)
  );

  // edge finder reads only the synchronised copy
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
      txclk_prev_reg <= 1'b0;
    else
      txclk_prev_reg <= txclk_s;
  end
  assign txclk_rise = txclk_s && !txclk_prev_reg;

  // -------------------------------------------------------------------------
  // write registers
  // -------------------------------------------------------------------------
  sec_enh_t    enh_reg;
  logic [7:0]  acc_reg;
  logic [7:0]  sync_reg;
  logic [7:0]  rxctl_reg;
  logic [7:0]  mode_reg;
  logic [7:0]  txctl_reg;
  logic [7:0]  enc_reg;
  logic [7:0]  misc_reg;
  logic [7:0]  dma_reg;
  logic        wr_enh;
  logic        sdlc;

  assign wr_enh = i_wr && i_addr == `SEC_ADDR_SYNC_ENH && acc_reg[`SEC_ACC_ENH_SEL];
  // sdlc: sync mode field 10 with sync modes selected
  assign sdlc   = mode_reg[3:2] == 2'b00 && mode_reg[5:4] == 2'b10;

  // enhancement register, own copy per channel; channel reset restores it
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
      enh_reg <= sec_enh_t'(`SEC_ENH_RESET);
    else if (i_chan_reset)
      enh_reg <= sec_enh_t'(`SEC_ENH_RESET);
    else if (wr_enh)
      enh_reg <= sec_enh_t'(i_wdata);
  end

  // ordinary write registers; address 7 hits sync only with bit 0 clear
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_reg   <= 8'h00;
      sync_reg  <= 8'h00;
      rxctl_reg <= 8'h00;
      mode_reg  <= 8'h00;
      txctl_reg <= 8'h00;
      enc_reg   <= 8'h00;
      misc_reg  <= 8'h00;
      dma_reg   <= 8'h00;
    end
    else if (i_wr)
    begin
      unique case (i_addr)
        `SEC_ADDR_ACC:      acc_reg   <= i_wdata;
        `SEC_ADDR_SYNC_ENH: if (!acc_reg[`SEC_ACC_ENH_SEL]) sync_reg <= i_wdata;
        `SEC_ADDR_RXCTL:    rxctl_reg <= i_wdata;
        `SEC_ADDR_MODE:     mode_reg  <= i_wdata;
        `SEC_ADDR_TXCTL:    txctl_reg <= i_wdata;
        `SEC_ADDR_ENC:      enc_reg   <= i_wdata;
        `SEC_ADDR_MISC:     misc_reg  <= i_wdata;
        `SEC_ADDR_DMA:      dma_reg   <= i_wdata;
        default:            ;
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // read port: data stand only in the cycle after the strobe
  // -------------------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_rdata <= 8'h00;
    else if (!i_rd)
      o_rdata <= 8'h00;
    else if (i_addr == `SEC_ADDR_ACC)
      o_rdata <= acc_reg;
    else if (i_addr == `SEC_RADDR_STAT0)
      o_rdata <= {5'h00, i_tx_top_empty, 1'b0, i_rx_level != 4'h0};
    else if (enh_reg.ext_read)
    begin
      unique case (i_addr)
        `SEC_RADDR_RXCTL: o_rdata <= rxctl_reg;
        `SEC_RADDR_MODE:  o_rdata <= mode_reg;
        `SEC_RADDR_TXCTL: o_rdata <= txctl_reg;
        `SEC_RADDR_ENH:   o_rdata <= enh_reg;
        `SEC_RADDR_ENC:   o_rdata <= enc_reg;
        default:          o_rdata <= 8'h00;
      endcase
    end
    else
      o_rdata <= 8'h00;
  end

  // -------------------------------------------------------------------------
  // transmit interrupt latch
  // -------------------------------------------------------------------------
  logic       tbe_cond;
  logic       tbe_prev_reg;
  logic       tbe_set;
  logic       tbe_clr;
  logic [1:0] tbe_cnt_reg;
  logic       req_lvl;

  assign tbe_cond = enh_reg.tx_level ? i_tx_fifo_empty : i_tx_top_empty;
  // an edge, crc load, or early eom clear, alone or together in one cycle, counts as one interrupt
  assign tbe_set  = (tbe_cond && !tbe_prev_reg) || i_crc_loaded
                    || (o_eom_clr && i_frame_active);
  assign tbe_clr  = i_wr && i_addr == `SEC_ADDR_CMD && i_wdata[`SEC_CMD_RST_TBE];

  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
      tbe_prev_reg <= 1'b0;
    else
      tbe_prev_reg <= tbe_cond;
  end

  // counted, so a late reset of the first cannot swallow the second
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
      tbe_cnt_reg <= 2'h0;
    else if (i_chan_reset)
      tbe_cnt_reg <= 2'h0;
    else if (tbe_set && !tbe_clr && tbe_cnt_reg != 2'h3)
      tbe_cnt_reg <= tbe_cnt_reg + 2'h1;
    else if (tbe_clr && !tbe_set && tbe_cnt_reg != 2'h0)
      tbe_cnt_reg <= tbe_cnt_reg - 2'h1; // set and clear together leave the count unchanged
  end

  // interrupt and request outputs
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_tx_irq  <= 1'b0;
      o_rx_irq  <= 1'b0;
      o_w_req_n <= 1'b1;
    end
    else
    begin
      o_tx_irq  <= tbe_cnt_reg != 2'h0 || tbe_set;
      o_rx_irq  <= enh_reg.rx_level ? i_rx_level >= `SEC_RX_HALF_LEVEL
                                    : i_rx_level != 4'h0;
      o_w_req_n <= !req_lvl;
    end
  end

  // -------------------------------------------------------------------------
  // request pins
  // -------------------------------------------------------------------------
  // receive request needs one byte only; transmit follows the tbe choice
  assign req_lvl = dma_reg[`SEC_DMA_REQ_EN]
                   && (dma_reg[`SEC_DMA_REQ_RX] ? i_rx_level != 4'h0
                                                : tbe_cond);

  sec_req_deact #(.DEACT(DEACT)) u_dtr_req (
    .i_clk   (i_core_clk),
    .i_rst_n (rst_n),
    .i_req   (req_lvl && misc_reg[`SEC_MISC_DTR_REQ]),
    .i_fast  (enh_reg.dtr_timing),
    .o_req_n (o_dtr_req_n)
  );

  // -------------------------------------------------------------------------
  // request-to-send
  // -------------------------------------------------------------------------
  sec_rts_st_t rts_st_reg;
  logic        rts_bit;

  assign rts_bit = txctl_reg[`SEC_TXCTL_RTS];

  // hold rts through the closing flag, release on the next tx clock rise
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rts_st_reg <= SEC_RTS_FOLLOW;
    else
    begin
      unique case (rts_st_reg)
        SEC_RTS_FOLLOW:
          if (!rts_bit && !o_rts_n && sdlc && enh_reg.auto_rts && i_frame_active)
            rts_st_reg <= SEC_RTS_HOLD;
        SEC_RTS_HOLD:
          if (rts_bit || !enh_reg.auto_rts || !sdlc)
            rts_st_reg <= SEC_RTS_FOLLOW;
          else if (i_flag_done)
            rts_st_reg <= SEC_RTS_CLKWAIT;
        SEC_RTS_CLKWAIT:
          if (txclk_rise || rts_bit)
            rts_st_reg <= SEC_RTS_FOLLOW;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_rts_n <= 1'b1;
    else if (rts_st_reg == SEC_RTS_FOLLOW
             && !(!rts_bit && !o_rts_n && sdlc && enh_reg.auto_rts && i_frame_active))
      o_rts_n <= !rts_bit;
    else if (rts_st_reg == SEC_RTS_CLKWAIT && txclk_rise)
      o_rts_n <= 1'b1;
  end

  // -------------------------------------------------------------------------
  // eom and crc automation, flag, crc capture, txd forcing
  // -------------------------------------------------------------------------
  logic force_high;

  assign force_high = sdlc && enc_reg[6:5] == 2'b01 && enc_reg[`SEC_ENC_MARK_IDLE]
                      && i_tx_mark_idle;

  // auto mode clears the latch on new data; command clears it in either mode
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_eom_clr    <= 1'b0;
      o_crc_preset <= 1'b0;
    end
    else
    begin
      o_eom_clr    <= i_eom_latch && ((enh_reg.auto_eom && i_tx_data_wr)
                      || (i_wr && i_addr == `SEC_ADDR_CMD && i_wdata[`SEC_CMD_RST_EOM]));
      o_crc_preset <= i_eom_latch && enh_reg.auto_eom && i_tx_data_wr;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_auto_flag   <= 1'b0;
      o_rx_crc_full <= 1'b0;
      o_txd         <= 1'b1;
    end
    else
    begin
      o_auto_flag   <= enh_reg.auto_flag && sdlc;
      o_rx_crc_full <= sdlc;
      o_txd         <= force_high || i_tx_serial;
    end
  end

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_enh_wr;
    i_wr && i_addr == `SEC_ADDR_SYNC_ENH && acc_reg[0] && !i_chan_reset;
  endsequence

  a_enh_write_path: assert property (s_enh_wr |=> enh_reg == $past(i_wdata))
    else $error("enhancement write lost");
  a_sync_kept: assert property (s_enh_wr |=> sync_reg == $past(sync_reg))
    else $error("sync written while access bit set");
  a_acc_readback: assert property (i_rd && i_addr == `SEC_ADDR_ACC
    |=> o_rdata[0] == $past(acc_reg[0]))
    else $error("access bit readback wrong");
  a_chan_reset: assert property (i_chan_reset |=> enh_reg == 8'h20)
    else $error("enhancement reset value wrong");
  a_ext_read: assert property (i_rd && i_addr == 4'hE && enh_reg.ext_read && !i_wr
    |=> o_rdata == $past(enh_reg))
    else $error("extended readback wrong");
  a_rx_irq_level: assert property (enh_reg.rx_level && i_rx_level == 4'h3
    && $stable(enh_reg) |=> !o_rx_irq)
    else $error("rx interrupt before four bytes");
  a_rts_track: assert property (!enh_reg.auto_rts && $stable(enh_reg.auto_rts)
    && rts_st_reg == SEC_RTS_FOLLOW |=> o_rts_n == !$past(rts_bit))
    else $error("rts not following control bit");
  a_rts_release: assert property (rts_st_reg == SEC_RTS_CLKWAIT && txclk_rise
    |=> o_rts_n ##1 rts_st_reg == SEC_RTS_FOLLOW [*1])
    else $error("rts not released on tx clock rise");
  a_txd_forced: assert property (force_high |=> o_txd)
    else $error("txd not forced high in mark idle");
  a_tbe_two: assert property (tbe_cnt_reg == 2'h2 && tbe_clr && !tbe_set
    |=> o_tx_irq ##1 tbe_cnt_reg != 2'h0 || tbe_clr)
    else $error("second tx interrupt lost");
  a_rx_dma_req: assert property (dma_reg[1:0] == 2'b11 && i_rx_level == 4'h1
    |=> !o_w_req_n)
    else $error("rx request missing");

endmodule // sec_chan

// ### tb/sec_line_model.sv
// Purpose: far-side line model that makes the transmit clock pin
// Assumes: the clock runs only while a frame is being sent
// Notes:   phase is unrelated to the core clock on purpose
`timescale 1ns/10ps
module sec_line_model (
  input  wire logic i_run,
  output logic      o_tx_clk
);
  // ---------------------------------------------------------------------
  // transmit clock, 80 ns period
  // ---------------------------------------------------------------------
  // stands low between frames so no stray edge reaches the sampler
  initial
  begin
    o_tx_clk = 1'b0;
    #13;
    forever
    begin
      #40;
      o_tx_clk = i_run ? ~o_tx_clk : 1'b0;
    end
  end
endmodule // sec_line_model

// ### tb/tb_top.sv
// Purpose: self-checking bench for one channel of enhancement control
// Assumes: read data stands only in the cycle after the read strobe
// Notes:   expectations come from the register layout, not the outputs
`timescale 1ns/10ps
`include "sec_map.svh"
`define CHK(n,e,v) begin num_checks++; if ((v) !== (e)) begin err_count++; \
  $display("unexpected %s exp %h got %h", n, e, v); end end
module tb_top;
  logic       i_core_clk = 1'b0;
  logic       i_nrst     = 1'b0;
  logic       i_wr       = 1'b0;
  logic       i_rd       = 1'b0;
  logic [3:0] i_addr     = 4'h0;
  logic [3:0] i_rx_level = 4'h0;
  logic [7:0] i_wdata    = 8'h00;
  logic [3:0] ev         = 4'h0;
  logic       i_tx_top_empty = 1'b0, i_tx_fifo_empty = 1'b0, i_frame_active = 1'b0;
  logic       i_eom_latch = 1'b0, i_tx_mark_idle = 1'b0, i_tx_serial = 1'b0;
  logic       i_tx_clk, o_txd, o_rts_n, o_w_req_n, o_dtr_req_n, o_tx_irq, o_rx_irq;
  logic       o_eom_clr, o_crc_preset, o_auto_flag, o_rx_crc_full, s_clr, s_pre;
  logic [7:0] o_rdata, d;
  int         err_count = 0, num_checks = 0, cyc = 0, k;
  // write addr, write data, read addr, expected read data
  logic [23:0] rows [10] = '{24'hF01F01, 24'h764E64, 24'h420420, 24'h502502,
    24'hA28B28, 24'h3C19C1, 24'hE04E64, 24'hF00F00, 24'h755E64, 24'h202200};

  // ---------------------------------------------------------------------
  // clock, design and far side
  // ---------------------------------------------------------------------
  always #2 i_core_clk = ~i_core_clk;
  sec_chan #(.DEACT(4)) i_sec_chan (.i_core_clk, .i_nrst, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .i_chan_reset(ev[3]), .i_tx_top_empty, .i_tx_fifo_empty,
    .i_tx_data_wr(ev[2]), .i_crc_loaded(ev[1]), .i_frame_active, .i_flag_done(ev[0]),
    .i_eom_latch, .i_tx_mark_idle, .i_tx_serial, .i_rx_level, .i_tx_clk, .o_txd,
    .o_rts_n, .o_w_req_n, .o_dtr_req_n, .o_tx_irq, .o_rx_irq, .o_eom_clr,
    .o_crc_preset, .o_auto_flag, .o_rx_crc_full);
  sec_line_model i_sec_line_model (.i_run(i_frame_active), .o_tx_clk(i_tx_clk));

  // ---------------------------------------------------------------------
  // bus and event tasks
  // ---------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_core_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_core_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  // one-cycle event pulse; events share one vector so a task can reach them
  task automatic pulse(input int b);
    @(posedge i_core_clk);
    ev[b] <= 1'b1;
    @(posedge i_core_clk);
    ev <= 4'h0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge i_core_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    tick(3);
    // enhancement writes land only while access bit 0 is set
    for (k = 0; k < 10; k++)
    begin
      wr(rows[k][23:20], rows[k][19:12]);
      rd(rows[k][11:8]);
      `CHK("readback", rows[k][7:0], d)
    end
    $display("test registers done");
    @(posedge i_core_clk) i_tx_mark_idle <= 1'b1;
    tick(3);
    `CHK("txd forced", 1'b1, o_txd)
    `CHK("crc full", 1'b1, o_rx_crc_full)
    wr(`SEC_ADDR_ENC, 8'h20);
    tick(3);
    `CHK("txd raw", 1'b0, o_txd)
    @(posedge i_core_clk) i_frame_active <= 1'b1;
    wr(`SEC_ADDR_MODE, 8'h00);
    wr(`SEC_ADDR_TXCTL, 8'h00);
    tick(2);
    `CHK("rts follow", 1'b1, o_rts_n)
    `CHK("crc drop", 1'b0, o_rx_crc_full)
    wr(`SEC_ADDR_MODE, 8'h20);
    wr(`SEC_ADDR_TXCTL, 8'h02);
    wr(`SEC_ADDR_TXCTL, 8'h00);
    tick(4);
    `CHK("rts held", 1'b0, o_rts_n)
    pulse(0);
    for (k = 0; k < 40 && o_rts_n !== 1'b1; k++)
      tick(1);
    `CHK("rts end", 1'b1, o_rts_n)
    @(posedge i_core_clk) i_frame_active <= 1'b0;
    $display("test line done");
    wr(`SEC_ADDR_DMA, 8'h01);
    @(posedge i_core_clk) i_tx_top_empty <= 1'b1;
    tick(3);
    `CHK("tx irq top", 1'b0, o_tx_irq)
    `CHK("req top", 1'b1, o_w_req_n)
    rd(`SEC_RADDR_STAT0);
    `CHK("status tbe", 1'b1, d[2])
    @(posedge i_core_clk) i_tx_fifo_empty <= 1'b1;
    tick(2);
    `CHK("tx irq fifo", 1'b1, o_tx_irq)
    pulse(1);
    wr(`SEC_ADDR_CMD, 8'h01);
    tick(2);
    `CHK("tx irq crc", 1'b1, o_tx_irq)
    wr(`SEC_ADDR_CMD, 8'h01);
    tick(2);
    `CHK("tx irq clear", 1'b0, o_tx_irq)
    @(posedge i_core_clk) i_tx_top_empty <= 1'b0;
    @(posedge i_core_clk) i_tx_fifo_empty <= 1'b0;
    wr(`SEC_ADDR_ACC, 8'h01);
    wr(`SEC_ADDR_SYNC_ENH, 8'h44);
    @(posedge i_core_clk) i_tx_top_empty <= 1'b1;
    tick(2);
    `CHK("tx irq byte", 1'b1, o_tx_irq)
    `CHK("req byte", 1'b0, o_w_req_n)
    @(posedge i_core_clk) i_tx_top_empty <= 1'b0;
    tick(2);
    `CHK("dtr slow", 2'b10, {o_w_req_n, o_dtr_req_n})
    tick(8);
    `CHK("dtr off", 1'b1, o_dtr_req_n)
    wr(`SEC_ADDR_SYNC_ENH, 8'h54);
    @(posedge i_core_clk) i_tx_top_empty <= 1'b1;
    tick(3);
    @(posedge i_core_clk) i_tx_top_empty <= 1'b0;
    for (k = 0; k < 5; k++)
    begin
      tick(1);
      `CHK("dtr fast", 2'b11, {o_w_req_n, o_dtr_req_n})
    end
    wr(`SEC_ADDR_CMD, 8'h01);
    wr(`SEC_ADDR_CMD, 8'h01);
    $display("test transmit done");
    wr(`SEC_ADDR_DMA, 8'h03);
    wr(`SEC_ADDR_SYNC_ENH, 8'h48);
    @(posedge i_core_clk) i_rx_level <= 4'h3;
    tick(2);
    `CHK("rx irq 3", 1'b0, o_rx_irq)
    `CHK("rx req", 1'b0, o_w_req_n)
    @(posedge i_core_clk) i_rx_level <= 4'h4;
    tick(2);
    `CHK("rx irq 4", 1'b1, o_rx_irq)
    wr(`SEC_ADDR_SYNC_ENH, 8'h40);
    @(posedge i_core_clk) i_rx_level <= 4'h1;
    tick(2);
    `CHK("rx irq 1", 1'b1, o_rx_irq)
    $display("test receive done");
    wr(`SEC_ADDR_SYNC_ENH, 8'h43);
    tick(2);
    `CHK("auto flag", 1'b1, o_auto_flag)
    @(posedge i_core_clk) i_frame_active <= 1'b1;
    @(posedge i_core_clk) i_eom_latch <= 1'b1;
    s_clr = 1'b0;
    s_pre = 1'b0;
    pulse(2);
    #1;
    // the clear and preset stand one cycle, from the edge that took the event
    for (k = 0; k < 6; k++)
    begin
      s_clr = s_clr | (o_eom_clr === 1'b1);
      s_pre = s_pre | (o_crc_preset === 1'b1);
      tick(1);
    end
    `CHK("eom clear", 2'b11, {s_clr, s_pre})
    `CHK("tx pend", 1'b1, o_tx_irq)
    @(posedge i_core_clk) i_frame_active <= 1'b0;
    pulse(3);
    tick(2);
    `CHK("reset flag", 1'b0, o_auto_flag)
    rd(`SEC_RADDR_ENH);
    `CHK("reset ext", 8'h00, d)
    $display("test automatic done");
    tally_and_finish();
  end
endmodule // tb_top
